// ==== sdb_pkg.sv ====
package sdb_pkg;
	localparam logic [7:0] SDB_ADDR = 8'h99;
	localparam logic [7:0] SDB_RESET = 8'h00;
	localparam int SYS_CLK_HZ = 25000000;
	localparam int BAUD_DEFAULT = 115200;
	localparam int BIT_CYCLES = SYS_CLK_HZ / BAUD_DEFAULT;
	localparam int DATA_BITS = 8;
	localparam logic [3:0] NINTH_IDX = 4'h8;

	typedef struct packed {
		logic [7:0] data;
		logic ninth;
	} tx_word_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b011,
		ST_STOP = 3'b010
	} tx_state_t;
endpackage : sdb_pkg

// ==== sdb_skid.sv ====
`timescale 1ns/1ps
module sdb_skid #(
	parameter int W = 9
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] mem_ff [2];
	logic [W-1:0] nxt_mem [2];
	logic [1:0] cnt_ff, nxt_cnt;
	logic rd_ff, nxt_rd;
	logic wr_ff, nxt_wr;
	logic push, pop;

	assign in_ready_o = (cnt_ff != 2'h2);
	assign out_valid_o = (cnt_ff != 2'h0);
	assign out_data_o = mem_ff[rd_ff];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_cnt = cnt_ff;
		nxt_rd = rd_ff;
		nxt_wr = wr_ff;
		if (push) begin
			nxt_mem[wr_ff] = in_data_i;
			nxt_wr = ~wr_ff;
		end
		if (pop) begin
			nxt_rd = ~rd_ff;
		end
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 2'h1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 2'h1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
			cnt_ff <= 2'h0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
		end else begin
			mem_ff <= nxt_mem;
			cnt_ff <= nxt_cnt;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
		end
	end

	// Fill level never passes two, and a full buffer refuses new words
	property p_no_overfill;
		@(posedge sys_clk_i) disable iff (rst_i)
		(cnt_ff <= 2'h2) && (cnt_ff != 2'h2 || !in_ready_o);
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("buffer accepts while full");
endmodule : sdb_skid

// ==== serial_data_buffer.sv ====
// Functional notes
// - The data buffer is decoded at register address 0x99 regardless of the selected page.
// - Behind that one address sit a transmit path and a separate receive latch.
// - A write loads the whole eight-bit byte for shifting out on the line.
// - Every byte write taken while wr_ready_o is high starts a serial transmission by itself; a write while it is low is dropped.
// - A read returns the receive latch, never the byte last written.
// - Transmit-done is set after bit eight in 8-bit mode, or at the stop bit start in 9-bit mode.
// - In 9-bit mode the ninth transmit bit control is sent after the eight data bits.
`timescale 1ns/1ps
module serial_data_buffer #(
	parameter int BIT_CYCLES = sdb_pkg::BIT_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Register access
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic wr_ready_o,
	// Serial port controls
	input wire logic nine_bit_mode_i,
	input wire logic ninth_transmit_bit_i,
	input wire logic rx_load_i,
	input wire logic [7:0] rx_byte_i,
	// Line and status
	output logic txd_o,
	output logic transmit_done_o,
	output logic tx_busy_o
);
	localparam int CW = $clog2(BIT_CYCLES + 1);

	logic sel, wr_hit;
	logic [7:0] rx_latch_ff, nxt_rx_latch;
	logic [7:0] rdata_ff, nxt_rdata;
	sdb_pkg::tx_state_t st_ff, nxt_st;
	logic [8:0] shreg_ff, nxt_shreg;
	logic [3:0] bit_ff, nxt_bit;
	logic [CW-1:0] tick_ff, nxt_tick;
	logic nine_ff, nxt_nine;
	logic txd_ff, nxt_txd;
	logic done_ff, nxt_done;
	logic bit_end;
	logic q_valid, q_ready;
	sdb_pkg::tx_word_t q_word, in_word;

	assign sel = (reg_addr_i == sdb_pkg::SDB_ADDR);
	assign wr_hit = sel && reg_wr_i;
	assign in_word = '{data: reg_wdata_i, ninth: ninth_transmit_bit_i};

	sdb_skid #(.W(9)) u_skid (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.in_valid_i(wr_hit),
		.in_ready_o(wr_ready_o),
		.in_data_i(in_word),
		.out_valid_o(q_valid),
		.out_ready_i(q_ready),
		.out_data_o(q_word)
	);

	// Receive latch and read data path, separate from the transmit path
	always_comb begin
		nxt_rx_latch = rx_latch_ff;
		nxt_rdata = rdata_ff;
		if (rx_load_i) begin
			nxt_rx_latch = rx_byte_i;
		end
		if (sel && reg_rd_i) begin
			nxt_rdata = rx_latch_ff;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_latch_ff <= sdb_pkg::SDB_RESET;
			rdata_ff <= sdb_pkg::SDB_RESET;
		end else begin
			rx_latch_ff <= nxt_rx_latch;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_o = rdata_ff;

	// Transmitter
	assign bit_end = (tick_ff == CW'(BIT_CYCLES - 1));
	assign q_ready = (st_ff == sdb_pkg::ST_IDLE);

	always_comb begin
		nxt_st = st_ff;
		nxt_shreg = shreg_ff;
		nxt_bit = bit_ff;
		nxt_tick = bit_end ? '0 : tick_ff + CW'(1);
		nxt_nine = nine_ff;
		nxt_txd = txd_ff;
		nxt_done = 1'b0;
		case (st_ff)
			sdb_pkg::ST_IDLE: begin
				nxt_tick = '0;
				nxt_txd = 1'b1;
				if (q_valid) begin
					nxt_shreg = {q_word.ninth, q_word.data};
					nxt_nine = nine_bit_mode_i;
					nxt_bit = 4'h0;
					nxt_txd = 1'b0;
					nxt_st = sdb_pkg::ST_START;
				end
			end
			sdb_pkg::ST_START: begin
				if (bit_end) begin
					nxt_txd = shreg_ff[0];
					nxt_shreg = {1'b0, shreg_ff[8:1]};
					nxt_st = sdb_pkg::ST_DATA;
				end
			end
			sdb_pkg::ST_DATA: begin
				if (bit_end) begin
					nxt_bit = bit_ff + 4'h1;
					if ((!nine_ff && bit_ff == 4'h7) || (nine_ff && bit_ff == sdb_pkg::NINTH_IDX)) begin
						nxt_txd = 1'b1;
						nxt_done = 1'b1;
						nxt_st = sdb_pkg::ST_STOP;
					end else begin
						nxt_txd = shreg_ff[0];
						nxt_shreg = {1'b0, shreg_ff[8:1]};
					end
				end
			end
			sdb_pkg::ST_STOP: begin
				if (bit_end) begin
					nxt_st = sdb_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_st = sdb_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= sdb_pkg::ST_IDLE;
			shreg_ff <= 9'h000;
			bit_ff <= 4'h0;
			tick_ff <= '0;
			nine_ff <= 1'b0;
			txd_ff <= 1'b1;
			done_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			shreg_ff <= nxt_shreg;
			bit_ff <= nxt_bit;
			tick_ff <= nxt_tick;
			nine_ff <= nxt_nine;
			txd_ff <= nxt_txd;
			done_ff <= nxt_done;
		end
	end

	assign txd_o = txd_ff;
	assign transmit_done_o = done_ff;
	assign tx_busy_o = (st_ff != sdb_pkg::ST_IDLE);

	property p_rd_latch;
		@(posedge sys_clk_i) disable iff (rst_i)
		sel && reg_rd_i |=> reg_rdata_o == $past(rx_latch_ff);
	endproperty
	a_rd_latch: assert property (p_rd_latch) else $error("read not from latch");

	property p_start;
		@(posedge sys_clk_i) disable iff (rst_i)
		st_ff == sdb_pkg::ST_IDLE && q_valid |=> !txd_o && st_ff == sdb_pkg::ST_START;
	endproperty
	a_start: assert property (p_start) else $error("write did not start frame");

	property p_done_stop;
		@(posedge sys_clk_i) disable iff (rst_i)
		transmit_done_o |-> st_ff == sdb_pkg::ST_STOP && txd_o && tick_ff == '0;
	endproperty
	a_done_stop: assert property (p_done_stop) else $error("done not at stop");

	property p_wr_queued;
		@(posedge sys_clk_i) disable iff (rst_i)
		wr_hit && wr_ready_o && st_ff == sdb_pkg::ST_IDLE && !q_valid
			|=> q_valid && q_word.data == $past(reg_wdata_i);
	endproperty
	a_wr_queued: assert property (p_wr_queued) else $error("byte not loaded");

	property p_decode;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i != sdb_pkg::SDB_ADDR && !q_valid
			&& st_ff == sdb_pkg::ST_IDLE |=> !q_valid;
	endproperty
	a_decode: assert property (p_decode) else $error("foreign address accepted");

	property p_ninth;
		@(posedge sys_clk_i) disable iff (rst_i)
		st_ff == sdb_pkg::ST_DATA && nine_ff && bit_ff == 4'h7 && bit_end
			|=> txd_o == $past(shreg_ff[0]);
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

	property p_rx_sep;
		@(posedge sys_clk_i) disable iff (rst_i)
		wr_hit && !rx_load_i |=> rx_latch_ff == $past(rx_latch_ff);
	endproperty
	a_rx_sep: assert property (p_rx_sep) else $error("write hit receive latch");

	property p_done_once;
		@(posedge sys_clk_i) disable iff (rst_i)
		transmit_done_o |=> !transmit_done_o;
	endproperty
	a_done_once: assert property (p_done_once) else $error("done longer than pulse");
endmodule : serial_data_buffer

// ==== line_rx.sv ====
`timescale 1ns/1ps
module line_rx #(
	parameter int BIT_CYCLES = 4
) (
	// Line
	input wire logic sys_clk_i,
	input wire logic txd_i,
	input wire logic nine_i,
	// Result
	output logic [8:0] word_o,
	output int frames_o
);
	int n;
	initial begin
		word_o = 9'h000;
		frames_o = 0;
		forever begin
			@(negedge txd_i);
			word_o = 9'h000;
			repeat (BIT_CYCLES / 2) @(posedge sys_clk_i);
			for (n = 0; n < (nine_i ? 9 : 8); n++) begin
				repeat (BIT_CYCLES) @(posedge sys_clk_i);
				word_o[n] = txd_i;
			end
			repeat (BIT_CYCLES) @(posedge sys_clk_i);
			// Only a frame with a high stop bit counts
			if (txd_i === 1'b1) frames_o++;
		end
	end
endmodule : line_rx

// ==== test_serial_data_buffer.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin fails++; \
	$display("[ERR] %s expected %h seen %h", n, e, s); end end
module test_serial_data_buffer;
	localparam int BC = 4;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic wr_ready;
	logic nine = 1'b0;
	logic ninth = 1'b0;
	logic rx_load = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	logic txd;
	logic done;
	logic busy;
	logic [8:0] word;
	int frames;
	int fails = 0;
	int compares = 0;
	int dones = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	always @(negedge sys_clk_i) if (done === 1'b1) dones++;
	serial_data_buffer #(.BIT_CYCLES(BC)) i_serial_data_buffer (.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .wr_ready_o(wr_ready), .nine_bit_mode_i(nine),
		.ninth_transmit_bit_i(ninth), .rx_load_i(rx_load), .rx_byte_i(rx_byte),
		.txd_o(txd), .transmit_done_o(done), .tx_busy_o(busy));
	line_rx #(.BIT_CYCLES(BC)) i_line_rx (.sys_clk_i(sys_clk_i), .txd_i(txd), .nine_i(nine),
		.word_o(word), .frames_o(frames));
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i) #1;
		addr = a; wdata = d; wr = 1'b1;
		// Hold the write until the buffer can take it
		@(negedge sys_clk_i);
		while (wr_ready !== 1'b1) @(negedge sys_clk_i);
		@(posedge sys_clk_i) #1;
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i) #1;
		addr = a; rd = 1'b1;
		@(posedge sys_clk_i) #1;
		rd = 1'b0;
		d = rdata;
	endtask : rd_reg
	task automatic wait_frames(input int k);
		int i;
		for (i = 0; i < 200 && frames != k; i++) @(posedge sys_clk_i);
		repeat (2 * BC) @(posedge sys_clk_i);
		`CHK("frames", k, frames)
		`CHK("dones", k, dones)
		`CHK("busy", 1'b0, busy)
	endtask : wait_frames
	task automatic t_rx_latch;
		logic [7:0] d;
		rd_reg(8'h99, d);
		`CHK("reset value", 8'h00, d)
		@(posedge sys_clk_i) #1;
		rx_byte = 8'ha5; rx_load = 1'b1;
		@(posedge sys_clk_i) #1;
		rx_load = 1'b0;
		wr_reg(8'h99, 8'h3c);
		rd_reg(8'h99, d);
		`CHK("rx latch", 8'ha5, d)
		wait_frames(1);
		`CHK("tx word", 9'h03c, word)
		wr_reg(8'h98, 8'h55);
		wait_frames(1);
		$display("test rx_latch done");
	endtask : t_rx_latch
	task automatic t_nine;
		@(posedge sys_clk_i) #1;
		nine = 1'b1;
		ninth = 1'b1;
		wr_reg(8'h99, 8'h81);
		wait_frames(2);
		`CHK("nine word", 9'h181, word)
		#1 nine = 1'b0;
		$display("test nine done");
	endtask : t_nine
	task automatic t_fill;
		wr_reg(8'h99, 8'h01);
		wr_reg(8'h99, 8'h02);
		wr_reg(8'h99, 8'h04);
		`CHK("wr_ready", 1'b0, wr_ready)
		wr_reg(8'h99, 8'h08);
		wait_frames(6);
		`CHK("last word", 9'h008, word)
		$display("test fill done");
	endtask : t_fill
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (10) @(posedge sys_clk_i);
		#1 rst_i = 1'b0;
		t_rx_latch();
		t_nine();
		t_fill();
		end_of_test();
	end
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
endmodule : test_serial_data_buffer
